// File: src/mad_pkg.sv
// package for the memory address decoder: address ranges, targets and carriers
// Function
// - boot rom enabled: program 0000-00FF goes to boot rom.
// - placement bit 1: program FE00-FEFF and FF00-FFFF both hit block zero.
// - placement bit 0: data 0100-01FF and 0200-02FF both hit block zero.
// - data 0300-03FF and 0400-04FF always hit block one.
// - data 7000-7FFF goes to the peripheral register window.
// - program FF00-FFFF is block zero only with placement bit 1, else reserved.
// - data 0200-02FF is block zero only with placement bit 0, else reserved.
package mad_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BLOCK_WORDS = 256;
  localparam int BLOCK_IDX_W = 8;
  localparam logic [15:0] BOOT_LO = 16'h0000;
  localparam logic [15:0] BOOT_HI = 16'h00FF;
  localparam logic [15:0] PROG_ROM_HI = 16'h0FFF;
  localparam logic [15:0] PROG_B0_ALIAS_LO = 16'hFE00;
  localparam logic [15:0] PROG_B0_ALIAS_HI = 16'hFEFF;
  localparam logic [15:0] PROG_B0_LO = 16'hFF00;
  localparam logic [15:0] PROG_B0_HI = 16'hFFFF;
  localparam logic [15:0] DATA_B0_ALIAS_LO = 16'h0100;
  localparam logic [15:0] DATA_B0_ALIAS_HI = 16'h01FF;
  localparam logic [15:0] DATA_B0_LO = 16'h0200;
  localparam logic [15:0] DATA_B0_HI = 16'h02FF;
  localparam logic [15:0] DATA_B1_LO = 16'h0300;
  localparam logic [15:0] DATA_B1_HI = 16'h03FF;
  localparam logic [15:0] DATA_B1_ALIAS_LO = 16'h0400;
  localparam logic [15:0] DATA_B1_ALIAS_HI = 16'h04FF;
  localparam logic [15:0] PERIPH_LO = 16'h7000;
  localparam logic [15:0] PERIPH_HI = 16'h7FFF;
  localparam logic [15:0] RESERVED_READ_VALUE = 16'h0000;
  localparam logic [15:0] DATA_RESET_VALUE = 16'h0000;

  typedef enum logic [1:0] {
    SPACE_PROGRAM = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO = 2'h2
  } mad_space_type;

  // one-hot target codes
  typedef enum logic [6:0] {
    TGT_RESERVED = 7'h01,
    TGT_BOOT_ROM = 7'h02,
    TGT_PROG_MEM = 7'h04,
    TGT_BLOCK_ZERO = 7'h08,
    TGT_BLOCK_ONE = 7'h10,
    TGT_PERIPH = 7'h20,
    TGT_EXTERNAL = 7'h40
  } mad_target_type;

  typedef struct packed {
    logic valid;
    logic write;
    mad_space_type space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mad_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } mad_rsp_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mad_fwd_type;
endpackage

// File: src/mad_dual_access_ram.sv
// one dual-access ram block held in flip-flops, one-cycle read latency
`timescale 1ns/100ps
module mad_dual_access_ram #(
  parameter int WORDS = 256,
  parameter int IDX_W = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic sel_i,
  input wire logic write_i,
  input wire logic [IDX_W-1:0] idx_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  initial begin
    if (WORDS != (1 << IDX_W)) $error("mad_dual_access_ram: WORDS must equal 2**IDX_W");
  end

  logic [15:0] mem_q [WORDS];
  logic [15:0] mem_d [WORDS];
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb begin
    mem_d = mem_q;
    rdata_d = rdata_q;
    if (sel_i && write_i) begin
      mem_d[idx_i] = wdata_i;
    end
    if (sel_i && !write_i) begin
      rdata_d = mem_q[idx_i];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= mad_pkg::DATA_RESET_VALUE;
      end
      rdata_q <= mad_pkg::DATA_RESET_VALUE;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule

// File: src/mad_memory_address_decoder.sv
// top of the memory address decoder: steers core accesses and holds both dual-access ram blocks
`timescale 1ns/100ps
module mad_memory_address_decoder #(
  parameter int BLOCK_WORDS = 256,
  parameter int BLOCK_IDX_W = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ram_block_placement_bit_i,
  input wire logic boot_rom_enable_i,
  input wire mad_pkg::mad_req_type req_i,
  output mad_pkg::mad_rsp_type rsp_o,
  output mad_pkg::mad_target_type target_o,
  output mad_pkg::mad_fwd_type boot_rom_o,
  input wire logic [15:0] boot_rom_rdata_i,
  output mad_pkg::mad_fwd_type prog_mem_o,
  input wire logic [15:0] prog_mem_rdata_i,
  output mad_pkg::mad_fwd_type periph_o,
  input wire logic [15:0] periph_rdata_i,
  output mad_pkg::mad_fwd_type external_o,
  input wire logic [15:0] external_rdata_i
);
  // the alias folding takes the low address byte as the word index, so only 256-word blocks fit
  if (BLOCK_WORDS != mad_pkg::BLOCK_WORDS) begin : g_bad_words
    $error("mad_memory_address_decoder: BLOCK_WORDS must be 256");
  end
  if (BLOCK_IDX_W != mad_pkg::BLOCK_IDX_W) begin : g_bad_index
    $error("mad_memory_address_decoder: BLOCK_IDX_W must be 8");
  end
  if (BLOCK_WORDS != (1 << BLOCK_IDX_W)) begin : g_bad_depth
    $error("mad_memory_address_decoder: BLOCK_WORDS must equal 2**BLOCK_IDX_W");
  end

  mad_pkg::mad_target_type target;
  mad_pkg::mad_target_type prog_target;
  mad_pkg::mad_target_type data_target;
  logic [15:0] a;

  function automatic logic in_range(
    input logic [15:0] x,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_range = (x >= lo) && (x <= hi);
  endfunction

  // one flag per address range keeps the priority chains below short
  logic hit_boot;
  logic hit_prog_rom;
  logic hit_prog_top;
  logic hit_prog_alias;
  logic hit_data_alias;
  logic hit_data_zero;
  logic hit_data_one;
  logic hit_periph;

  assign a = req_i.addr;

  always_comb begin
    hit_boot = in_range(a, mad_pkg::BOOT_LO, mad_pkg::BOOT_HI);
    hit_prog_rom = in_range(a, mad_pkg::BOOT_LO, mad_pkg::PROG_ROM_HI);
    hit_prog_top = in_range(a, mad_pkg::PROG_B0_LO, mad_pkg::PROG_B0_HI);
    hit_prog_alias = in_range(a, mad_pkg::PROG_B0_ALIAS_LO, mad_pkg::PROG_B0_ALIAS_HI);
    hit_data_alias = in_range(a, mad_pkg::DATA_B0_ALIAS_LO, mad_pkg::DATA_B0_ALIAS_HI);
    hit_data_zero = in_range(a, mad_pkg::DATA_B0_LO, mad_pkg::DATA_B0_HI);
    hit_data_one = in_range(a, mad_pkg::DATA_B1_LO, mad_pkg::DATA_B1_ALIAS_HI);
    hit_periph = in_range(a, mad_pkg::PERIPH_LO, mad_pkg::PERIPH_HI);
  end

  // program space: the boot rom overrides the low rom words while it is enabled
  always_comb begin
    prog_target = mad_pkg::TGT_RESERVED;
    if (boot_rom_enable_i && hit_boot) begin
      prog_target = mad_pkg::TGT_BOOT_ROM;
    end else if (hit_prog_rom) begin
      prog_target = mad_pkg::TGT_PROG_MEM;
    end else if (hit_prog_top) begin
      // reserved with the bit clear
      prog_target = ram_block_placement_bit_i ? mad_pkg::TGT_BLOCK_ZERO : mad_pkg::TGT_RESERVED;
    end else if (hit_prog_alias) begin
      // alias of block zero, else the external range
      prog_target = ram_block_placement_bit_i ? mad_pkg::TGT_BLOCK_ZERO : mad_pkg::TGT_EXTERNAL;
    end
  end

  // data space: block zero and its alias leave data space when the bit moves it to program space
  always_comb begin
    data_target = mad_pkg::TGT_RESERVED;
    if (hit_data_alias) begin
      data_target = ram_block_placement_bit_i ? mad_pkg::TGT_RESERVED : mad_pkg::TGT_BLOCK_ZERO;
    end else if (hit_data_zero) begin
      data_target = ram_block_placement_bit_i ? mad_pkg::TGT_RESERVED : mad_pkg::TGT_BLOCK_ZERO;
    end else if (hit_data_one) begin
      data_target = mad_pkg::TGT_BLOCK_ONE;
    end else if (hit_periph) begin
      data_target = mad_pkg::TGT_PERIPH;
    end
  end

  // decode is purely combinational so every access completes with no wait state
  always_comb begin
    if (req_i.space == mad_pkg::SPACE_PROGRAM) begin
      target = prog_target;
    end else if (req_i.space == mad_pkg::SPACE_DATA) begin
      target = data_target;
    end else begin
      target = mad_pkg::TGT_EXTERNAL;
    end
  end

  logic sel_b0;
  logic sel_b1;
  logic [15:0] b0_rdata;
  logic [15:0] b1_rdata;

  // reserved targets raise no select, so no storage changes
  assign sel_b0 = req_i.valid && (target == mad_pkg::TGT_BLOCK_ZERO);
  assign sel_b1 = req_i.valid && (target == mad_pkg::TGT_BLOCK_ONE);

  // low eight bits index the block, which folds both alias ranges onto one word
  mad_dual_access_ram #(.WORDS(BLOCK_WORDS), .IDX_W(BLOCK_IDX_W)) u_dual_access_block_zero (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .sel_i(sel_b0),
    .write_i(req_i.write),
    .idx_i(a[BLOCK_IDX_W-1:0]),
    .wdata_i(req_i.wdata),
    .rdata_o(b0_rdata)
  );

  mad_dual_access_ram #(.WORDS(BLOCK_WORDS), .IDX_W(BLOCK_IDX_W)) u_dual_access_block_one (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .sel_i(sel_b1),
    .write_i(req_i.write),
    .idx_i(a[BLOCK_IDX_W-1:0]),
    .wdata_i(req_i.wdata),
    .rdata_o(b1_rdata)
  );

  // the four outside targets share one strobe shape, so one loop builds them all
  localparam int N_OUTSIDE = 4;
  localparam mad_pkg::mad_target_type OUTSIDE_TGT [N_OUTSIDE] = '{
    mad_pkg::TGT_BOOT_ROM,
    mad_pkg::TGT_PROG_MEM,
    mad_pkg::TGT_PERIPH,
    mad_pkg::TGT_EXTERNAL
  };
  mad_pkg::mad_fwd_type outside_fwd [N_OUTSIDE];

  for (genvar g = 0; g < N_OUTSIDE; g++) begin : g_outside
    assign outside_fwd[g] = '{valid: req_i.valid && (target == OUTSIDE_TGT[g]), write: req_i.write,
                              addr: req_i.addr, wdata: req_i.wdata};
  end

  assign boot_rom_o = outside_fwd[0];
  assign prog_mem_o = outside_fwd[1];
  assign periph_o = outside_fwd[2];
  assign external_o = outside_fwd[3];

  // read steering is delayed one cycle to line up with the block read register
  logic rd_valid_q;
  logic rd_valid_d;
  mad_pkg::mad_target_type rd_target_q;
  mad_pkg::mad_target_type rd_target_d;
  logic rd_req;

  // a write never raises an answer; every read answers in the next cycle, reserved ones too
  assign rd_req = req_i.valid && !req_i.write;

  always_comb begin
    rd_valid_d = rd_req;
    rd_target_d = rd_valid_d ? target : rd_target_q;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_q <= 1'b0;
      rd_target_q <= mad_pkg::TGT_RESERVED;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_target_q <= rd_target_d;
    end
  end

  // outside memories answer in their strobe cycle and the word is registered; reserved gives a fixed value
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (rd_req) begin
      case (target)
        mad_pkg::TGT_BOOT_ROM: rdata_d = boot_rom_rdata_i;
        mad_pkg::TGT_PROG_MEM: rdata_d = prog_mem_rdata_i;
        mad_pkg::TGT_PERIPH: rdata_d = periph_rdata_i;
        mad_pkg::TGT_EXTERNAL: rdata_d = external_rdata_i;
        default: rdata_d = mad_pkg::RESERVED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= mad_pkg::DATA_RESET_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rsp_o.valid = rd_valid_q;
    case (rd_target_q)
      mad_pkg::TGT_BLOCK_ZERO: rsp_o.rdata = b0_rdata;
      mad_pkg::TGT_BLOCK_ONE: rsp_o.rdata = b1_rdata;
      default: rsp_o.rdata = rdata_q;
    endcase
  end

  assign target_o = target;
endmodule

// File: verification/mad_decoder_chk.sv
// port assertions for the memory address decoder
`timescale 1ns/100ps
module mad_decoder_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ram_block_placement_bit_i,
  input wire logic boot_rom_enable_i,
  input wire mad_pkg::mad_req_type req_i,
  input wire mad_pkg::mad_rsp_type rsp_o,
  input wire mad_pkg::mad_target_type target_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic pv, dv, cb;
  logic [7:0] hi;
  assign pv = req_i.valid && req_i.space == mad_pkg::SPACE_PROGRAM;
  assign dv = req_i.valid && req_i.space == mad_pkg::SPACE_DATA;
  assign cb = ram_block_placement_bit_i;
  assign hi = req_i.addr[15:8];
  sequence s_resv_read; req_i.valid && !req_i.write && target_o == mad_pkg::TGT_RESERVED; endsequence
  sequence s_zero_answer; rsp_o.valid && rsp_o.rdata == 16'h0000; endsequence
  sequence s_read_taken; req_i.valid && !req_i.write; endsequence
  a_boot_route: assert property (pv && boot_rom_enable_i && hi == 8'h00 |-> target_o == mad_pkg::TGT_BOOT_ROM)
    else $error("boot rom not selected");
  a_prog_alias: assert property (pv && cb && hi[7:1] == 7'h7f |-> target_o == mad_pkg::TGT_BLOCK_ZERO)
    else $error("program alias missed block zero");
  a_data_alias: assert property (dv && !cb && hi inside {8'h01, 8'h02} |-> target_o == mad_pkg::TGT_BLOCK_ZERO)
    else $error("data alias missed block zero");
  a_blk_one: assert property (dv && hi inside {8'h03, 8'h04} |-> target_o == mad_pkg::TGT_BLOCK_ONE)
    else $error("block one not selected");
  a_periph_route: assert property (dv && req_i.addr[15:12] == 4'h7 |-> target_o == mad_pkg::TGT_PERIPH)
    else $error("peripheral window not selected");
  a_prog_top: assert property (pv && !cb && hi == 8'hff |-> target_o == mad_pkg::TGT_RESERVED)
    else $error("program top not reserved");
  a_data_top: assert property (dv && cb && hi == 8'h02 |-> target_o == mad_pkg::TGT_RESERVED)
    else $error("data 0200 range not reserved");
  a_resv_read: assert property (s_resv_read |=> s_zero_answer)
    else $error("reserved read answer wrong");
  a_read_answer: assert property (s_read_taken |=> rsp_o.valid)
    else $error("read got no answer in the next cycle");
  a_no_spare_answer: assert property (!(req_i.valid && !req_i.write) |=> !rsp_o.valid)
    else $error("answer raised without a read");
  a_prog_external: assert property (pv && !cb && hi == 8'hfe |-> target_o == mad_pkg::TGT_EXTERNAL)
    else $error("program fe range not external");
endmodule

bind mad_memory_address_decoder mad_decoder_chk u_mad_decoder_chk (.clock_i, .rstn_i, .ram_block_placement_bit_i,
  .boot_rom_enable_i, .req_i, .rsp_o, .target_o);

// File: verification/mad_target_model.sv
// far-side target model: answers a forwarded strobe with its address xor a key
`timescale 1ns/100ps
module mad_target_model #(
  parameter logic [15:0] KEY = 16'h0000
) (
  input wire logic clock_i,
  input wire mad_pkg::mad_fwd_type fwd_i,
  output logic [15:0] rdata_o
);
  // unselected: a word that moves every cycle, so a stale sample never matches by luck
  logic [15:0] idle_q = 16'h5a5a;
  always @(posedge clock_i) idle_q <= idle_q + 16'h3a5b;
  assign rdata_o = fwd_i.valid ? fwd_i.addr ^ KEY : idle_q;
endmodule

// File: verification/mad_memory_address_decoder_tb.sv
// self-checking bench for the memory address decoder
`timescale 1ns/100ps
module mad_memory_address_decoder_tb;
  localparam mad_pkg::mad_space_type PROG = mad_pkg::SPACE_PROGRAM, DATA = mad_pkg::SPACE_DATA;
  localparam mad_pkg::mad_target_type T_ZERO = mad_pkg::TGT_BLOCK_ZERO, T_ONE = mad_pkg::TGT_BLOCK_ONE;
  localparam mad_pkg::mad_target_type T_RES = mad_pkg::TGT_RESERVED, T_BOOT = mad_pkg::TGT_BOOT_ROM;
  localparam mad_pkg::mad_target_type T_PROG = mad_pkg::TGT_PROG_MEM, T_PERI = mad_pkg::TGT_PERIPH;
  localparam mad_pkg::mad_target_type T_EXT = mad_pkg::TGT_EXTERNAL;
  logic clock_i = 1'b0, rstn_i = 1'b0, placement = 1'b0, boot_en = 1'b0;
  mad_pkg::mad_req_type req = '0;
  mad_pkg::mad_rsp_type rsp;
  mad_pkg::mad_target_type tgt;
  mad_pkg::mad_fwd_type boot_f, prog_f, peri_f, ext_f;
  logic [15:0] boot_d, prog_d, peri_d, ext_d;
  int n_errors = 0, tests_run = 0;
  always #4 clock_i = ~clock_i;
  mad_memory_address_decoder u_mad_memory_address_decoder (.clock_i, .rstn_i, .ram_block_placement_bit_i(placement),
    .boot_rom_enable_i(boot_en), .req_i(req), .rsp_o(rsp), .target_o(tgt), .boot_rom_o(boot_f),
    .boot_rom_rdata_i(boot_d), .prog_mem_o(prog_f), .prog_mem_rdata_i(prog_d), .periph_o(peri_f),
    .periph_rdata_i(peri_d), .external_o(ext_f), .external_rdata_i(ext_d));
  mad_target_model #(.KEY(16'hb000)) u_mad_target_model_boot (.clock_i, .fwd_i(boot_f), .rdata_o(boot_d));
  mad_target_model #(.KEY(16'hc000)) u_mad_target_model_prog (.clock_i, .fwd_i(prog_f), .rdata_o(prog_d));
  mad_target_model #(.KEY(16'h9000)) u_mad_target_model_peri (.clock_i, .fwd_i(peri_f), .rdata_o(peri_d));
  mad_target_model #(.KEY(16'he000)) u_mad_target_model_ext (.clock_i, .fwd_i(ext_f), .rdata_o(ext_d));
  task automatic check(input string what, input logic [15:0] seen, want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  // valid stays up between calls so accesses run back to back; for reads d is the expected word
  task automatic acc(input logic w, input mad_pkg::mad_space_type s, input logic [15:0] a, d,
    input mad_pkg::mad_target_type t);
    req = '{1'b1, w, s, a, w ? d : 16'h0000};
    #1 check("target", 16'(tgt), 16'(t));
    @(posedge clock_i);
    #1 if (!w) begin
      check("answer valid", 16'(rsp.valid), 16'h0001);
      check("read data", rsp.rdata, d);
    end
  endtask
  task automatic idle(input string name);
    req.valid = 1'b0;
    @(posedge clock_i);
    #1 $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_data;
    acc(1'b1, DATA, 16'h0105, 16'h1234, T_ZERO);
    acc(1'b0, DATA, 16'h0205, 16'h1234, T_ZERO);
    acc(1'b1, DATA, 16'h0405, 16'habcd, T_ONE);
    acc(1'b0, DATA, 16'h0305, 16'habcd, T_ONE);
    acc(1'b1, DATA, 16'h02f0, 16'h7777, T_ZERO);
    placement = 1'b1;
    acc(1'b1, DATA, 16'h02f0, 16'h0bad, T_RES);
    acc(1'b0, DATA, 16'h02f0, 16'h0000, T_RES);
    placement = 1'b0;
    acc(1'b0, DATA, 16'h02f0, 16'h7777, T_ZERO);
    idle("data aliases");
  endtask
  task automatic t_prog;
    placement = 1'b1;
    acc(1'b1, PROG, 16'hfe22, 16'h5a5a, T_ZERO);
    acc(1'b0, PROG, 16'hff22, 16'h5a5a, T_ZERO);
    placement = 1'b0;
    acc(1'b0, PROG, 16'hff22, 16'h0000, T_RES);
    idle("program aliases");
  endtask
  task automatic t_route;
    boot_en = 1'b1;
    acc(1'b0, PROG, 16'h00ff, 16'hb0ff, T_BOOT);
    boot_en = 1'b0;
    acc(1'b0, PROG, 16'h00ff, 16'hc0ff, T_PROG);
    acc(1'b0, DATA, 16'h7000, 16'he000, T_PERI);
    acc(1'b0, DATA, 16'h6fff, 16'h0000, T_RES);
    idle("routing");
  endtask
  // the external strobe must carry every field while the request stands, and must not touch block zero
  task automatic t_outside;
    acc(1'b0, PROG, 16'hfe22, 16'h1e22, T_EXT);
    acc(1'b0, mad_pkg::SPACE_IO, 16'h0123, 16'he123, T_EXT);
    acc(1'b0, PROG, 16'h1000, mad_pkg::RESERVED_READ_VALUE, T_RES);
    req = '{1'b1, 1'b1, PROG, 16'hfe30, 16'h4321};
    #1 check("external valid", 16'(ext_f.valid), 16'h0001);
    check("external write", 16'(ext_f.write), 16'h0001);
    check("external addr", ext_f.addr, 16'hfe30);
    check("external wdata", ext_f.wdata, 16'h4321);
    check("program strobe", 16'(prog_f.valid), 16'h0000);
    @(posedge clock_i);
    #1 placement = 1'b1;
    acc(1'b0, PROG, 16'hfe30, mad_pkg::DATA_RESET_VALUE, T_ZERO);
    placement = 1'b0;
    idle("outside targets");
  endtask
  // reset in mid-run drops a standing answer at once and clears block one
  task automatic t_reset;
    acc(1'b1, DATA, 16'h0333, 16'h9999, T_ONE);
    acc(1'b0, DATA, 16'h0333, 16'h9999, T_ONE);
    req.valid = 1'b0;
    rstn_i = 1'b0;
    #1 check("answer valid in reset", 16'(rsp.valid), 16'h0000);
    check("answer data in reset", rsp.rdata, mad_pkg::DATA_RESET_VALUE);
    @(posedge clock_i);
    #1 rstn_i = 1'b1;
    acc(1'b0, DATA, 16'h0433, mad_pkg::DATA_RESET_VALUE, T_ONE);
    idle("mid-run reset");
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    t_data;
    t_prog;
    t_route;
    t_outside;
    t_reset;
    report_and_stop;
  end
  initial begin
    repeat (400) @(posedge clock_i);
    n_errors++;
    report_and_stop;
  end
endmodule
